/* rtl/ddr_cmd_pkg.sv */
// Purpose: constants for the mode register and command decoder
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes:   mode field layout, command codes and timing counts
// Summary of operation
// RULE_01: opcode bit 3 selects sequential or interleaved
// RULE_02: latency 2 or 2.5 clocks legal
// RULE_03: first read data at edge n plus m
// RULE_04: burst order by length, type, start column
// RULE_05: bursts wrap inside aligned burst-length block
// RULE_06: opcode bits 7-12 zero selects normal mode
// RULE_07: opcode bit 8 alone starts DLL reset
// RULE_08: controller follows DLL reset with normal load
// RULE_09: controller avoids other bit 7-12 combinations
// RULE_10: extended register holds DLL enable, drive strength
// RULE_11: controller resets DLL after enabling it
// RULE_12: controller loads registers only when idle
// RULE_13: self refresh exit re-enables the DLL
// RULE_14: controller waits 200 clocks before read
// RULE_15: commands decode from select and strobe pins
// RULE_16: activate gives bank and 13-bit row
// RULE_17: read/write bit 10 requests auto precharge
// RULE_18: burst terminate only on plain read bursts
// RULE_19: precharge bit 10 high closes all banks
// RULE_20: refresh pattern: auto or self by cke
// RULE_21: bank code picks mode or extended register
// RULE_22: output FET control is not supported
// RULE_23: opcode fields: length, type, latency, mode
// RULE_24: command inputs registered one extra clock
// RULE_25: controller programs both registers before access
package ddr_cmd_pkg;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 13;
  localparam int COL_W      = 12;
  localparam int BL_LSB     = 0;
  localparam int BL_W       = 3;
  localparam int BT_BIT     = 3;
  localparam int CL_LSB     = 4;
  localparam int CL_W       = 3;
  localparam int OPM_LSB    = 7;
  localparam int OPM_W      = 6;
  localparam int DLL_DIS_BIT = 0;
  localparam int DRV_BIT    = 1;
  localparam int AP_BIT     = 10;
  localparam int COL_HI_BIT = 11;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] BL_2      = 3'h1;
  localparam logic [2:0] BL_4      = 3'h2;
  localparam logic [2:0] BL_8      = 3'h3;
  localparam logic [2:0] CL_2      = 3'h2;
  localparam logic [2:0] CL_25     = 3'h6;
  localparam logic [5:0] OPM_NORM  = 6'h00;
  localparam logic [5:0] OPM_DLLR  = 6'h02;
  localparam logic [1:0] BA_MODE   = 2'h0;
  localparam logic [1:0] BA_EXT    = 2'h1;
  // half-clock latency steps: 2 clocks = 4, 2.5 clocks = 5
  localparam logic [3:0] HLAT_2    = 4'h4;
  localparam logic [3:0] HLAT_25   = 4'h5;
  // reset values of the two registers
  localparam logic [12:0] MODE_RST = 13'h0000;
  localparam logic [12:0] EXT_RST  = 13'h0000;

  // command pattern {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] P_LMR  = 3'h0;
  localparam logic [2:0] P_REF  = 3'h1;
  localparam logic [2:0] P_PRE  = 3'h2;
  localparam logic [2:0] P_ACT  = 3'h3;
  localparam logic [2:0] P_WR   = 3'h4;
  localparam logic [2:0] P_RD   = 3'h5;
  localparam logic [2:0] P_BST  = 3'h6;
  localparam logic [2:0] P_NOP  = 3'h7;

  typedef enum logic [3:0] {
    CMD_DESEL, CMD_NOP, CMD_LMR, CMD_AREF, CMD_SREF, CMD_PRE,
    CMD_ACT, CMD_WR, CMD_RD, CMD_BST
  } cmd_type;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int DLL_LOCK_CLK = 200;
  localparam logic [7:0] DLL_LOCK_CNT = 8'(DLL_LOCK_CLK);
  localparam logic [3:0] BEAT_ONE = 4'h1;

endpackage

/* rtl/ddr_cmd_decode.sv */
// Purpose: command decode and mode registers of a DDR memory
// Assumes: inputs synchronous to clk_i, cke_i sampled per edge
// Notes:   commands are registered then applied one clock later;
//          burst beat column index runs one beat per clock
module ddr_cmd_decode
  import ddr_cmd_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cke_i,
  input  wire logic              cs_n_i,
  input  wire logic              ras_n_i,
  input  wire logic              cas_n_i,
  input  wire logic              we_n_i,
  input  wire logic [1:0]        ba_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic [3:0]             cmd_o,
  output logic                   illegal_o,
  output logic                   act_o,
  output logic [1:0]             act_bank_o,
  output logic [ADDR_W-1:0]      act_row_o,
  output logic                   pre_o,
  output logic [3:0]             pre_banks_o,
  output logic                   aref_o,
  output logic                   self_ref_o,
  output logic                   burst_o,
  output logic                   burst_wr_o,
  output logic                   auto_pre_o,
  output logic [1:0]             burst_bank_o,
  output logic [COL_W-1:0]       burst_col_o,
  output logic                   rd_data_o,
  output logic                   rd_half_o,
  output logic [2:0]             burst_len_o,
  output logic                   interleave_o,
  output logic [2:0]             latency_o,
  output logic [5:0]             op_mode_o,
  output logic                   dll_enable_o,
  output logic                   drive_weak_o,
  output logic                   dll_reset_o,
  output logic                   dll_ready_o,
  output logic                   bad_mode_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              in_cs_n;
    logic              in_ras_n;
    logic              in_cas_n;
    logic              in_we_n;
    logic              in_cke;
    logic [1:0]        in_ba;
    logic [ADDR_W-1:0] in_addr;
    logic [3:0]        cmd;
    logic              illegal;
    logic              act;
    logic [1:0]        act_bank;
    logic [ADDR_W-1:0] act_row;
    logic              pre;
    logic [3:0]        pre_banks;
    logic              aref;
    logic              self_ref;
    logic [12:0]       mode;
    logic [12:0]       ext;
    logic              dll_reset;
    logic [7:0]        lock_cnt;
    logic              dll_ready;
    logic              bad_mode;
    logic              burst;
    logic              burst_wr;
    logic              auto_pre;
    logic [1:0]        burst_bank;
    logic [COL_W-1:0]  base_col;
    logic [3:0]        beat;
    logic [COL_W-1:0]  burst_col;
    logic [3:0]        lat_cnt;
    logic              rd_pend;
    logic [3:0]        rd_beats;
    logic              rd_data;
    logic              rd_half;
  } state_type;

  state_type s_q;
  state_type s_d;

  cmd_type     dec;
  logic [2:0]  pat;
  logic [3:0]  blen;
  logic [2:0]  lowmask;
  logic [2:0]  start;
  logic [2:0]  offs;
  logic [3:0]  hlat;
  logic [3:0]  lat_clk;
  logic [3:0]  nbeat;

  // decoded command on the internally applied (registered) inputs
  always_comb begin
    pat = {s_q.in_ras_n, s_q.in_cas_n, s_q.in_we_n};
    if (s_q.in_cs_n) begin
      dec = CMD_DESEL; // RULE_15
    end else begin
      case (pat)
        P_LMR:   dec = CMD_LMR;
        P_REF:   dec = s_q.in_cke ? CMD_AREF : CMD_SREF; // RULE_20
        P_PRE:   dec = CMD_PRE;
        P_ACT:   dec = CMD_ACT;
        P_WR:    dec = CMD_WR;
        P_RD:    dec = CMD_RD;
        P_BST:   dec = CMD_BST;
        P_NOP:   dec = CMD_NOP;
        default: dec = CMD_NOP;
      endcase
    end
  end

  // burst length, wrap mask and read latency from the mode register
  always_comb begin
    case (s_q.mode[BL_LSB +: BL_W]) // RULE_23
      BL_2:    begin blen = 4'h2; lowmask = 3'h1; end
      BL_4:    begin blen = 4'h4; lowmask = 3'h3; end
      BL_8:    begin blen = 4'h8; lowmask = 3'h7; end
      default: begin blen = 4'h2; lowmask = 3'h1; end
    endcase
    case (s_q.mode[CL_LSB +: CL_W]) // RULE_02
      CL_25:   hlat = HLAT_25;
      default: hlat = HLAT_2;
    endcase
    lat_clk = {1'b0, hlat[3:1]};
    start = s_q.base_col[2:0] & lowmask;
    // offset of the beat that follows the one now shown
    nbeat = s_q.beat + BEAT_ONE;
    // RULE_01 RULE_04
    if (s_q.mode[BT_BIT])
      offs = (start ^ nbeat[2:0]) & lowmask;
    else
      offs = (start + nbeat[2:0]) & lowmask;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // capture inputs, apply next clock
    s_d.in_cs_n  = cs_n_i; // RULE_24
    s_d.in_ras_n = ras_n_i;
    s_d.in_cas_n = cas_n_i;
    s_d.in_we_n  = we_n_i;
    s_d.in_cke   = cke_i;
    s_d.in_ba    = ba_i;
    s_d.in_addr  = addr_i;
    s_d.cmd      = 4'(dec);
    s_d.act      = 1'b0;
    s_d.pre      = 1'b0;
    s_d.aref     = 1'b0;
    s_d.illegal  = 1'b0;
    s_d.dll_reset = 1'b0;
    s_d.rd_data  = 1'b0;
    s_d.rd_half  = 1'b0;

    // lock count runs first so a reload below always wins
    if (s_q.lock_cnt != 8'h00 && s_q.in_cke)
      s_d.lock_cnt = s_q.lock_cnt - 8'h01;
    // self refresh held while cke low; exit re-enables the DLL
    if (s_q.self_ref && s_q.in_cke) begin
      s_d.self_ref = 1'b0;
      s_d.ext[DLL_DIS_BIT] = 1'b0; // RULE_13
      s_d.lock_cnt = DLL_LOCK_CNT;
    end

    // burst column walk, wrapping in the block
    if (s_q.burst) begin
      s_d.burst_col = {s_q.base_col[COL_W-1:3],
                       (s_q.base_col[2:0] & ~lowmask) | offs}; // RULE_05
      s_d.beat = s_q.beat + BEAT_ONE;
      if (s_q.beat == blen - BEAT_ONE)
        s_d.burst = 1'b0;
    end

    // read data window: first beat lands n+m clocks after the read
    if (s_q.rd_pend) begin
      if (s_q.lat_cnt == BEAT_ONE) begin
        s_d.rd_pend  = 1'b0;
        s_d.rd_data  = 1'b1; // RULE_03
        s_d.rd_half  = hlat[0];
        s_d.rd_beats = (blen >> 1) - BEAT_ONE;
      end else begin
        s_d.lat_cnt = s_q.lat_cnt - BEAT_ONE;
      end
    end else if (s_q.rd_beats != 4'h0) begin
      s_d.rd_data  = 1'b1;
      s_d.rd_half  = hlat[0];
      s_d.rd_beats = s_q.rd_beats - BEAT_ONE;
    end

    case (dec)
      CMD_ACT: begin
        s_d.act      = 1'b1;
        s_d.act_bank = s_q.in_ba; // RULE_16
        s_d.act_row  = s_q.in_addr;
      end
      CMD_PRE: begin
        s_d.pre = 1'b1;
        if (s_q.in_addr[AP_BIT])
          s_d.pre_banks = 4'hF; // RULE_19
        else
          s_d.pre_banks = 4'h1 << s_q.in_ba;
      end
      CMD_AREF: s_d.aref = 1'b1; // RULE_20
      CMD_SREF: s_d.self_ref = 1'b1;
      CMD_RD, CMD_WR: begin
        s_d.burst      = 1'b1;
        s_d.burst_wr   = (dec == CMD_WR);
        s_d.auto_pre   = s_q.in_addr[AP_BIT]; // RULE_17
        s_d.burst_bank = s_q.in_ba;
        s_d.base_col   = {s_q.in_addr[COL_HI_BIT], 1'b0,
                          s_q.in_addr[9:0]};
        s_d.beat       = 4'h0;
        s_d.burst_col  = s_d.base_col;
        s_d.rd_beats   = 4'h0;
        if (dec == CMD_RD) begin
          s_d.rd_pend = 1'b1;
          s_d.lat_cnt = lat_clk;
        end else begin
          s_d.rd_pend = 1'b0;
        end
      end
      CMD_BST: begin
        // only meaningful on reads without auto precharge
        if (!s_q.burst_wr && !s_q.auto_pre) begin // RULE_18
          s_d.burst    = 1'b0;
          s_d.rd_pend  = 1'b0;
          s_d.rd_beats = 4'h0;
        end
      end
      CMD_LMR: begin
        case (s_q.in_ba) // RULE_21
          BA_MODE: begin
            s_d.mode = s_q.in_addr;
            // RULE_06 RULE_07
            if (s_q.in_addr[OPM_LSB +: OPM_W] == OPM_DLLR) begin
              s_d.dll_reset = 1'b1;
              s_d.mode[OPM_LSB +: OPM_W] = OPM_NORM; // bit 8 self-clears
              s_d.lock_cnt = DLL_LOCK_CNT;
            end
            s_d.bad_mode =
              (s_q.in_addr[OPM_LSB +: OPM_W] != OPM_NORM) &&
              (s_q.in_addr[OPM_LSB +: OPM_W] != OPM_DLLR);
          end
          BA_EXT: begin
            // only DLL disable and drive strength are kept
            s_d.ext = 13'h0000; // RULE_22
            s_d.ext[DLL_DIS_BIT] = s_q.in_addr[DLL_DIS_BIT]; // RULE_10
            s_d.ext[DRV_BIT]     = s_q.in_addr[DRV_BIT];
            if (s_q.ext[DLL_DIS_BIT] && !s_q.in_addr[DLL_DIS_BIT])
              s_d.lock_cnt = DLL_LOCK_CNT;
          end
          default: s_d.illegal = 1'b1;
        endcase
      end
      default: ;
    endcase

    if (rst_i) begin
      s_d = '0;
      s_d.in_cs_n  = 1'b1;
      s_d.in_ras_n = 1'b1;
      s_d.in_cas_n = 1'b1;
      s_d.in_we_n  = 1'b1;
      s_d.mode     = MODE_RST;
      s_d.ext      = EXT_RST;
      s_d.lock_cnt = DLL_LOCK_CNT;
    end
    // ready flag kept in a flop so the output needs no decode
    s_d.dll_ready = (s_d.lock_cnt == 8'h00);
  end

  // register the whole state
  always_ff @(posedge clk_i) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmd_o        = s_q.cmd;
  assign illegal_o    = s_q.illegal;
  assign act_o        = s_q.act;
  assign act_bank_o   = s_q.act_bank;
  assign act_row_o    = s_q.act_row;
  assign pre_o        = s_q.pre;
  assign pre_banks_o  = s_q.pre_banks;
  assign aref_o       = s_q.aref;
  assign self_ref_o   = s_q.self_ref;
  assign burst_o      = s_q.burst;
  assign burst_wr_o   = s_q.burst_wr;
  assign auto_pre_o   = s_q.auto_pre;
  assign burst_bank_o = s_q.burst_bank;
  assign burst_col_o  = s_q.burst_col;
  assign rd_data_o    = s_q.rd_data;
  assign rd_half_o    = s_q.rd_half;
  assign burst_len_o  = s_q.mode[BL_LSB +: BL_W];
  assign interleave_o = s_q.mode[BT_BIT];
  assign latency_o    = s_q.mode[CL_LSB +: CL_W];
  assign op_mode_o    = s_q.mode[OPM_LSB +: OPM_W];
  assign dll_enable_o = ~s_q.ext[DLL_DIS_BIT];
  assign drive_weak_o = s_q.ext[DRV_BIT];
  assign dll_reset_o  = s_q.dll_reset;
  assign dll_ready_o  = s_q.dll_ready;
  assign bad_mode_o   = s_q.bad_mode;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_lmr_dllr;
    !cs_n_i && !ras_n_i && !cas_n_i && !we_n_i && ba_i == BA_MODE &&
    addr_i[OPM_LSB +: OPM_W] == OPM_DLLR;
  endsequence

  property p_dll_reset;
    @(posedge clk_i) disable iff (rst_i)
    s_lmr_dllr |-> ##2 dll_reset_o;
  endproperty
  a_dll_reset: assert property (p_dll_reset) // RULE_07
    else $error("dll reset pulse missing");

  property p_act;
    @(posedge clk_i) disable iff (rst_i)
    (!cs_n_i && !ras_n_i && ras_n_i == 1'b0 && cas_n_i && we_n_i)
      |-> ##2 (act_o && act_row_o == $past(addr_i, 2));
  endproperty
  a_act: assert property (p_act) // RULE_16
    else $error("activate row not reported");

  property p_pre_all;
    @(posedge clk_i) disable iff (rst_i)
    (!cs_n_i && !ras_n_i && cas_n_i && !we_n_i && addr_i[AP_BIT])
      |-> ##2 (pre_o && pre_banks_o == 4'hF);
  endproperty
  a_pre_all: assert property (p_pre_all) // RULE_19
    else $error("precharge all wrong");

  property p_refresh;
    @(posedge clk_i) disable iff (rst_i)
    (!cs_n_i && !ras_n_i && !cas_n_i && we_n_i && cke_i)
      |-> ##2 aref_o;
  endproperty
  a_refresh: assert property (p_refresh) // RULE_20
    else $error("auto refresh missing");

  property p_sref_exit;
    @(posedge clk_i) disable iff (rst_i)
    (self_ref_o && $rose(s_q.in_cke)) |=> (dll_enable_o && !self_ref_o);
  endproperty
  a_sref_exit: assert property (p_sref_exit) // RULE_13
    else $error("dll not re-enabled on self refresh exit");

  property p_ap;
    @(posedge clk_i) disable iff (rst_i)
    (!cs_n_i && ras_n_i && !cas_n_i)
      |-> ##2 (burst_o && auto_pre_o == $past(addr_i[AP_BIT], 2));
  endproperty
  a_ap: assert property (p_ap) // RULE_17
    else $error("auto precharge flag wrong");

  property p_rd_lat;
    @(posedge clk_i) disable iff (rst_i)
    (!cs_n_i && ras_n_i && !cas_n_i && we_n_i && latency_o == CL_2)
      ##1 (latency_o == CL_2)
      |-> !rd_data_o ##1 !rd_data_o ##1 !rd_data_o ##1 rd_data_o;
  endproperty
  a_rd_lat: assert property (p_rd_lat) // RULE_03
    else $error("read data latency wrong");

  property p_order;
    @(posedge clk_i) disable iff (rst_i)
    (burst_o && $past(burst_o) && burst_len_o == BL_4)
      |-> burst_col_o[COL_W-1:2] == $past(burst_col_o[COL_W-1:2]);
  endproperty
  a_order: assert property (p_order) // RULE_05
    else $error("burst left its block");

  property p_ext_fet;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |-> s_q.ext[12:2] == 11'h000;
  endproperty
  a_ext_fet: assert property (p_ext_fet) // RULE_22
    else $error("unsupported extended bit stored");

endmodule

/* dv/ddr_ctl_model.sv */
// Purpose: memory controller model driving the command pins
// Assumes: one clock; pins change by non-blocking assignment at posedge
// Notes:   issue() sends one command for one cycle, then deselects
module ddr_ctl_model
  import ddr_cmd_pkg::*;
(
  input  wire logic              clk_i,
  output logic                   cke_o,
  output logic                   cs_n_o,
  output logic                   ras_n_o,
  output logic                   cas_n_o,
  output logic                   we_n_o,
  output logic [1:0]             ba_o,
  output logic [ADDR_W-1:0]      addr_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] lock_cnt;
  logic       lock_clr;

  // idle: deselected, strobes high
  initial begin
    cke_o = 1'b1;
    cs_n_o = 1'b1;
    {ras_n_o, cas_n_o, we_n_o} = P_NOP;
    ba_o = 2'h0;
    addr_o = 13'h0000;
    lock_cnt = 8'h00;
    lock_clr = 1'b0;
  end

  // clocks with clock enable high since the last DLL enable or reset
  always @(posedge clk_i) begin
    if (lock_clr) begin
      lock_cnt <= 8'h00;
    end else if (cke_o && lock_cnt != 8'hFF) begin
      lock_cnt <= lock_cnt + 8'h01;
    end
  end

  // one command; reads held back until the DLL has had its clocks
  task automatic issue(input logic k, input logic s, input logic [2:0] p,
                       input logic [1:0] b, input logic [12:0] a);
    logic clr;
    int   w;
    clr = (!s && p == P_LMR && ((b == BA_EXT && !a[0]) ||
          (b == BA_MODE && a[8]))) || (!cke_o && k);
    w = 0;
    while (!s && p == P_RD && lock_cnt < DLL_LOCK_CNT && w < 300) begin
      @(posedge clk_i);
      w++;
    end
    // a lock wait that never ends counts against the run
    if (w == 300) begin
      tb_top.n_fail++;
    end
    @(posedge clk_i);
    cke_o <= k;
    cs_n_o <= s;
    {ras_n_o, cas_n_o, we_n_o} <= p;
    ba_o <= b;
    addr_o <= a;
    lock_clr <= clr;
    @(posedge clk_i);
    // deselected: address toggles so stale values are not mistaken
    cs_n_o <= 1'b1;
    {ras_n_o, cas_n_o, we_n_o} <= P_NOP;
    addr_o <= ~a;
    lock_clr <= 1'b0;
  endtask
endmodule

/* dv/tb_top.sv */
// Purpose: self-checking bench of the command decoder
// Assumes: outputs settle one edge after the command is sampled
// Notes:   register and DLL setup first, then command table, bursts and corner cases
module tb_top
  import ddr_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic        cs_n;
    logic [2:0]  pat;
    logic [1:0]  ba;
    logic [12:0] addr;
    logic [3:0]  cmd;
    logic [15:0] aux;
  } row_type;

  logic clk_i, rst_i, cke, cs_n, ras_n, cas_n, we_n;
  logic [1:0] ba, act_bank_o, burst_bank_o;
  logic [12:0] addr, act_row_o;
  logic [3:0] cmd_o, pre_banks_o;
  logic [11:0] burst_col_o;
  logic [2:0] burst_len_o, latency_o;
  logic [5:0] op_mode_o;
  logic illegal_o, act_o, pre_o, aref_o, self_ref_o, burst_o, burst_wr_o;
  logic auto_pre_o, rd_data_o, rd_half_o, interleave_o, dll_enable_o;
  logic drive_weak_o, dll_reset_o, dll_ready_o, bad_mode_o;
  int n_fail = 0;
  int n_compared = 0;

  row_type rows [10] = '{
    '{1'b0, P_ACT, 2'h2, 13'h1ABC, CMD_ACT, 16'h5ABC},
    '{1'b0, P_RD, 2'h1, 13'h0005, CMD_RD, 16'h0000},
    '{1'b0, P_BST, 2'h0, 13'h0000, CMD_BST, 16'h0000},
    '{1'b0, P_WR, 2'h1, 13'h0405, CMD_WR, 16'h0003},
    '{1'b0, P_PRE, 2'h1, 13'h0000, CMD_PRE, 16'h0002},
    '{1'b0, P_PRE, 2'h1, 13'h0400, CMD_PRE, 16'h000F},
    '{1'b0, P_REF, 2'h0, 13'h0000, CMD_AREF, 16'h0001},
    '{1'b0, P_NOP, 2'h0, 13'h0000, CMD_NOP, 16'h0000},
    '{1'b1, P_LMR, 2'h0, 13'h0000, CMD_DESEL, 16'h0000},
    '{1'b0, P_LMR, 2'h0, 13'h002A, CMD_LMR, 16'h0052}
  };

  ddr_ctl_model ctl_i (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n),
    .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba),
    .addr_o(addr));

  ddr_cmd_decode ddr_cmd_decode_i (.clk_i(clk_i), .rst_i(rst_i),
    .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n),
    .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .cmd_o(cmd_o),
    .illegal_o(illegal_o), .act_o(act_o), .act_bank_o(act_bank_o),
    .act_row_o(act_row_o), .pre_o(pre_o), .pre_banks_o(pre_banks_o),
    .aref_o(aref_o), .self_ref_o(self_ref_o), .burst_o(burst_o),
    .burst_wr_o(burst_wr_o), .auto_pre_o(auto_pre_o),
    .burst_bank_o(burst_bank_o), .burst_col_o(burst_col_o),
    .rd_data_o(rd_data_o), .rd_half_o(rd_half_o),
    .burst_len_o(burst_len_o), .interleave_o(interleave_o),
    .latency_o(latency_o), .op_mode_o(op_mode_o),
    .dll_enable_o(dll_enable_o), .drive_weak_o(drive_weak_o),
    .dll_reset_o(dll_reset_o), .dll_ready_o(dll_ready_o),
    .bad_mode_o(bad_mode_o));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // issue one command and wait until its effect shows
  task automatic send(input logic k, input logic s, input logic [2:0] p,
                      input logic [1:0] b, input logic [12:0] a);
    ctl_i.issue(k, s, p, b, a);
    @(posedge clk_i);
    #1;
  endtask

  // side output that belongs to each command
  function automatic logic [15:0] aux_of(input logic [3:0] c);
    case (c)
      CMD_ACT:        return 16'({act_bank_o, act_row_o});
      CMD_PRE:        return 16'(pre_banks_o);
      CMD_AREF:       return 16'(aref_o);
      CMD_LMR:        return 16'({interleave_o, burst_len_o, latency_o});
      CMD_RD, CMD_WR: return 16'({burst_wr_o, auto_pre_o});
      default:        return 16'h0000;
    endcase
  endfunction

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int len;
    int off;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(16'({cmd_o, dll_enable_o, dll_ready_o, burst_o}), 16'h0004);
    // both registers programmed, DLL reset, then normal mode
    send(1'b1, 1'b0, P_LMR, BA_EXT, 13'h0002);
    chk(16'({drive_weak_o, dll_enable_o}), 16'h0003);
    send(1'b1, 1'b0, P_LMR, BA_MODE, 13'h0122);
    chk(16'({dll_reset_o, dll_ready_o}), 16'h0002);
    send(1'b1, 1'b0, P_LMR, BA_MODE, 13'h0022);
    chk(16'(op_mode_o), 16'h0000);
    repeat (200) @(posedge clk_i);
    chk(16'(dll_ready_o), 16'h0001);
    // command table
    foreach (rows[r]) begin
      send(1'b1, rows[r].cs_n, rows[r].pat, rows[r].ba, rows[r].addr);
      chk(16'(cmd_o), 16'(rows[r].cmd));
      chk(aux_of(cmd_o), rows[r].aux);
    end
    // burst order, wrap and read data timing for every mode
    for (int c = 0; c < 2; c++) begin
      for (int b = 1; b < 4; b++) begin
        for (int t = 0; t < 2; t++) begin
          len = 1 << b;
          send(1'b1, 1'b0, P_LMR, BA_MODE,
               13'(((c != 0 ? CL_25 : CL_2) << 4) | (t << 3) | b));
          chk(16'({interleave_o, burst_len_o, latency_o}),
              16'({t[0], b[2:0], (c != 0 ? CL_25 : CL_2)}));
          send(1'b1, 1'b0, P_RD, 2'h0, 13'h08F5);
          for (int i = 0; i < len + 3; i++) begin
            off = (t != 0) ? (5 ^ i) : (5 + i);
            if (i < len) begin
              chk(16'(burst_col_o), 16'((12'h8F5 & ~(len - 1)) |
                  (off & (len - 1))));
            end
            chk(16'(burst_o), 16'(i < len));
            chk(16'(rd_data_o), 16'(i >= 2 && i < 2 + len / 2));
            chk(16'(rd_half_o),
                16'(c != 0 && i >= 2 && i < 2 + len / 2));
            @(posedge clk_i);
            #1;
          end
        end
      end
    end
    // burst stop honoured only on plain reads
    send(1'b1, 1'b0, P_LMR, BA_MODE, 13'h0023);
    for (int t = 0; t < 2; t++) begin
      ctl_i.issue(1'b1, 1'b0, P_RD, 2'h0, (t != 0) ? 13'h0400 : 13'h0000);
      ctl_i.issue(1'b1, 1'b0, P_BST, 2'h0, 13'h0000);
      repeat (4) @(posedge clk_i);
      #1;
      chk(16'({burst_o, auto_pre_o}), 16'(t * 3));
      repeat (10) @(posedge clk_i);
    end
    // reserved bank code and reserved operating mode
    send(1'b1, 1'b0, P_LMR, 2'h2, 13'h0000);
    chk(16'({illegal_o, burst_len_o}), 16'h000B);
    send(1'b1, 1'b0, P_LMR, BA_MODE, 13'h00A3);
    chk(16'(bad_mode_o), 16'h0001);
    send(1'b1, 1'b0, P_LMR, BA_MODE, 13'h0023);
    chk(16'(bad_mode_o), 16'h0000);
    // DLL off, self refresh, exit turns the DLL back on
    send(1'b1, 1'b0, P_LMR, BA_EXT, 13'h0001);
    chk(16'(dll_enable_o), 16'h0000);
    send(1'b0, 1'b0, P_REF, 2'h0, 13'h0000);
    chk(16'({cmd_o, self_ref_o}), 16'({CMD_SREF, 1'b1}));
    send(1'b1, 1'b0, P_NOP, 2'h0, 13'h0000);
    chk(16'({self_ref_o, dll_enable_o}), 16'h0001);
    stop_test();
  end
endmodule
